// [rtl/fgp_pkg.sv]
// Purpose: Constants for the four-pin I/O port block
// Assumes: AHB-Lite register access, 32-bit data
// Notes: One register word at byte address 14h
package fgp_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] PIN_IO_CONTROL_OFFSET = 8'h14;
  localparam int ADDR_BITS = 8;

  // ------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------
  localparam int VALUE_LSB = 4;
  localparam int DIR_LSB = 0;
  localparam int PIN_COUNT = 4;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [3:0] DIR_RESET = 4'hF;
  localparam logic [3:0] LATCH_RESET = 4'h0;

  // ------------------------------------------------------------
  // AHB encodings
  // ------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

// [rtl/fgp_sync.sv]
// Purpose: Two-stage synchroniser for a group of pin levels
// Assumes: Clock enable freezes both stages
// Notes: First stage read only by second stage
`timescale 1ns/100ps
`default_nettype none
module fgp_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_ff <= '0;
      q_out <= '0;
    end else if (ce_in) begin
      meta_ff <= d_in;
      q_out <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// [rtl/fgp_port.sv]
// Purpose: Four-pin general-purpose I/O port behind one AHB-Lite register
// Assumes: All inputs synchronous to CORE_CLK_IN, except pin levels
// Notes: Zero-wait-state slave, every transfer answered OKAY
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module fgp_port #(
  parameter int PINS = 4
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic [PINS-1:0] PIN_IN,
  output logic [PINS-1:0] PIN_OUT,
  output logic [PINS-1:0] PIN_OE_OUT
);

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (PINS != fgp_pkg::PIN_COUNT) begin : g_bad_pins
    $error("PINS must equal four to fit the register layout");
  end

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic hit_reg(input logic [31:0] addr);
    hit_reg = (addr[fgp_pkg::ADDR_BITS-1:0] ==
               fgp_pkg::PIN_IO_CONTROL_OFFSET) &&
              (addr[31:fgp_pkg::ADDR_BITS] == '0);
  endfunction

  logic active;
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic [PINS-1:0] dir_ff;
  logic [PINS-1:0] latch_ff;
  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] nxt_dir;
  logic [PINS-1:0] nxt_latch;
  logic [PINS-1:0] new_dir;

  assign active = HSEL_IN && HREADY_IN && HTRANS_IN[1];

  // ------------------------------------------------------------
  // Address phase capture
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
    end else if (CE_IN) begin
      wr_pend_ff <= active && HWRITE_IN && hit_reg(HADDR_IN);
      rd_pend_ff <= active && !HWRITE_IN && hit_reg(HADDR_IN);
    end
  end

  // ------------------------------------------------------------
  // Register update
  // ------------------------------------------------------------
  always_comb begin
    nxt_dir = dir_ff;
    nxt_latch = latch_ff;
    new_dir = HWDATA_IN[fgp_pkg::DIR_LSB +: PINS];
    if (wr_pend_ff) begin
      nxt_dir = new_dir;
      for (int i = 0; i < PINS; i++) begin
        if (!new_dir[i]) begin
          nxt_latch[i] = HWDATA_IN[fgp_pkg::VALUE_LSB + i];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      dir_ff <= fgp_pkg::DIR_RESET;
      latch_ff <= fgp_pkg::LATCH_RESET;
    end else if (CE_IN) begin
      dir_ff <= nxt_dir;
      latch_ff <= nxt_latch;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  // Release input pins
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      PIN_OUT <= '0;
      PIN_OE_OUT <= '0;
    end else if (CE_IN) begin
      PIN_OUT <= nxt_latch;
      PIN_OE_OUT <= ~nxt_dir;
    end
  end

  fgp_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CE_IN),
    .d_in(PIN_IN),
    .q_out(pin_sync)
  );

  // ------------------------------------------------------------
  // Read data and response
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      HRDATA_OUT <= '0;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end else if (CE_IN) begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
      if (active && !HWRITE_IN && hit_reg(HADDR_IN)) begin
        HRDATA_OUT <= {24'h000000, pin_sync, nxt_dir};
      end else begin
        HRDATA_OUT <= '0;
      end
    end
  end

endmodule
`default_nettype wire

// [test/fgp_chk.sv]
// Purpose: Bus and pin checks for fgp_port
// Assumes: CE_IN held high
// Notes: Bound after the module
`timescale 1ns/100ps
`default_nettype none
module fgp_chk #(parameter int PINS = 4) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic [PINS-1:0] PIN_IN,
  input wire logic [PINS-1:0] PIN_OUT,
  input wire logic [PINS-1:0] PIN_OE_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic rd, hit, wr_ff;
  assign hit = HSEL_IN & HTRANS_IN[1] & (HADDR_IN == 32'h14);
  assign rd = HSEL_IN & HTRANS_IN[1] & !HWRITE_IN;
  always_ff @(posedge CORE_CLK_IN) wr_ff <= RST_N_IN & hit & HWRITE_IN;
  property p_oe; wr_ff |=> PIN_OE_OUT == ~$past(HWDATA_IN[3:0]); endproperty
  a_oe: assert property (p_oe) else $error("dir bad");
  property p_drv;
    wr_ff |=> ((PIN_OUT ^ $past(HWDATA_IN[7:4])) & PIN_OE_OUT) == 4'h0;
  endproperty
  a_drv: assert property (p_drv) else $error("drive bad");
  property p_keep;
    wr_ff |=> ((PIN_OUT ^ $past(PIN_OUT)) & ~PIN_OE_OUT) == 4'h0;
  endproperty
  a_keep: assert property (p_keep) else $error("latch bad");
  property p_dir; !wr_ff |=> $stable(PIN_OE_OUT); endproperty
  a_dir: assert property (p_dir) else $error("dir moved");
  property p_pin; rd & hit |=> HRDATA_OUT[7:4] == $past(PIN_IN, 3); endproperty
  a_pin: assert property (p_pin) else $error("pin read bad");
  property p_ctl; rd & hit |=> HRDATA_OUT[3:0] == ~PIN_OE_OUT; endproperty
  a_ctl: assert property (p_ctl) else $error("dir read bad");
  property p_map; rd & !hit |=> HRDATA_OUT == 32'h0; endproperty
  a_map: assert property (p_map) else $error("unmapped bad");
  c_wr: cover property (wr_ff);
  c_rd: cover property (rd & hit);
  c_map: cover property (rd & !hit);
endmodule
bind fgp_port fgp_chk #(.PINS(PINS)) fgp_chk_inst (.*);
`default_nettype wire

// [test/fgp_pins.sv]
// Purpose: Board wiring around the four pins
// Assumes: Board drives every released pin
// Notes: No pull resistors fitted
`timescale 1ns/100ps
`default_nettype none
module fgp_pins (
  input wire logic [3:0] drv_in,
  input wire logic [3:0] oe_in,
  input wire logic [3:0] board_in,
  output logic [3:0] lvl_out
);
  assign lvl_out = (oe_in & drv_in) | (~oe_in & board_in);
endmodule
`default_nettype wire

// [test/four_pin_gpio_port_tb_top.sv]
// Purpose: Register and pin tests for fgp_port
// Assumes: Zero-wait AHB-Lite slave
// Notes: Board holds pins at 5
`timescale 1ns/100ps
`default_nettype none
module four_pin_gpio_port_tb_top;
  logic clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, rdy, hresp;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [3:0] pout, oe, lvl;
  logic [15:0] tv [5] = '{16'hA5F5, 16'h0555, 16'h0F5F, 16'h0000, 16'hF0F0};
  int err_total = 0, n_compared = 0;
  always #50 clk = ~clk;
  fgp_port fgp_port_inst (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'h1),
    .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(rdy), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(rdy), .HRESP_OUT(hresp), .PIN_IN(lvl), .PIN_OUT(pout),
    .PIN_OE_OUT(oe));
  fgp_pins fgp_pins_inst (.drv_in(pout), .oe_in(oe), .board_in(4'h5),
    .lvl_out(lvl));
  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'h1 && n < 20);
    if (rdy !== 1'h1) begin
      err_total++;
      report_and_stop;
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    r = hrdata;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    xfer(1'h0, 32'h14, 32'h0);
    chk(r, 32'h5F);
    chk({31'h0, hresp}, 32'h0);
    foreach (tv[i]) begin
      xfer(1'h1, 32'h14, {24'h0, tv[i][15:8]});
      // Let the synchroniser settle
      repeat (3) @(posedge clk);
      xfer(1'h0, 32'h14, 32'h0);
      chk(r, {24'h0, tv[i][7:0]});
    end
    xfer(1'h1, 32'h14, 32'h0F);
    xfer(1'h0, 32'h14, 32'h0);
    chk({28'h0, r[3:0]}, 32'hF);
    xfer(1'h1, 32'h10, 32'h00);
    xfer(1'h0, 32'h18, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    xfer(1'h0, 32'h14, 32'h0);
    chk(r, 32'h5F);
    report_and_stop;
  end
endmodule
`default_nettype wire
